// ### design/err_counter.v
// Errored-byte counter of the self-test checker with lock snapshot
`timescale 1ns/10ps
`include "phy_selftest_defs.vh"
module err_counter #(
	parameter W = 8
) (
	input wire ref_clk,
	input wire rst_n,
	input wire err_byte,
	input wire wrap_mode,
	input wire lock,
	output reg [W-1:0] count_q,
	output reg [W-1:0] held_q
);
	// Running count; lock wins so a byte in the lock cycle is dropped with the old count
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= {W{1'b0}};
			held_q <= {W{1'b0}};
		end
		else if (lock)
		begin
			held_q <= count_q; // [RQ8]
			count_q <= {W{1'b0}}; // [RQ8]
		end
		else if (err_byte && (wrap_mode || count_q != {W{1'b1}}))
		begin
			count_q <= count_q + {{(W-1){1'b0}}, 1'b1}; // [RQ7] [RQ9]
		end
	end
endmodule

// ### design/phy_irq3_and_prbs_selftest_regs.v
// Interrupt status/enable and self-test configuration registers
//
// How it works
// RQ1: Power-on-reset done event latches status bit 12 until read.
// RQ2: No-frame-detected event latches status bit 11 until read.
// RQ3: Link-partner-state event latches status bit 8 until read.
// RQ4: Bit 4 enables power-on-reset done interrupt, resets to one.
// RQ5: Bit 3 enables no-frame interrupt, resets to zero.
// RQ6: Bit 0 enables link-partner-state interrupt, resets to zero.
// RQ7: Bits 15:8 show the checker's errored-byte count, reset zero.
// RQ8: Writing one to bit 15 snapshots the count and clears the counter.
// RQ9: With wrap mode low the counter stops at 0xff.
// RQ10: Bits 7:0 hold generator gap in four-byte units, reset 0x7d.
// RQ11: Bits 10:0 hold packet length in bytes, reset 0x5ee, upper zero.
// RQ12: Interrupt high while any latched status has its enable set; read clears.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "phy_selftest_defs.vh"
module phy_irq3_and_prbs_selftest_regs (
	input wire ref_clk,
	input wire rst_n,
	input wire [8:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata_q,
	input wire por_done_evt,
	input wire no_frame_evt,
	input wire link_partner_state_event,
	input wire err_byte,
	input wire err_wrap_mode,
	output reg [7:0] gap_words_q,
	output reg [10:0] pkt_len_q,
	output wire irq
);
	// Address decode results per mapped register, with the write, status-read and lock strobes built from them
	wire sel_stat;
	wire sel_selftest;
	wire sel_len;
	wire wr_stat;
	wire wr_selftest;
	wire wr_len;
	wire rd_stat;
	wire err_lock;

	// Latched event flags
	reg por_st_q;
	reg por_st_d;
	reg nof_st_q;
	reg nof_st_d;
	reg lpe_st_q;
	reg lpe_st_d;

	// Interrupt enables
	reg por_en_q;
	reg por_en_d;
	reg nof_en_q;
	reg nof_en_d;
	reg lpe_en_q;
	reg lpe_en_d;

	// Generator configuration next values
	reg [7:0] gap_words_d;
	reg [10:0] pkt_len_d;

	// Snapshot of the errored-byte count, the only count software sees
	wire [7:0] err_held;

	// Read path and interrupt sources
	reg [15:0] rdata_d;
	wire pend_por;
	wire pend_nof;
	wire pend_lpe;

	// Exact match of the bus address against one register offset
	function addr_is;
		input [8:0] a;
		input [8:0] ofs;
		begin
			addr_is = (a == ofs);
		end
	endfunction

	// Sticky flag next state; a new event beats a read-clear so nothing is lost
	function sticky_next;
		input cur;
		input evt;
		input clr;
		begin
			sticky_next = evt | (cur & ~clr);
		end
	endfunction

	// Writable bit next state: take the bus bit on a write, else hold
	function field_bit_next;
		input cur;
		input we;
		input wbit;
		begin
			if (we)
				field_bit_next = wbit;
			else
				field_bit_next = cur;
		end
	endfunction

	// Status register image; reserved bits stay zero
	function [15:0] stat_image;
		input por_st;
		input nof_st;
		input lpe_st;
		input por_en;
		input nof_en;
		input lpe_en;
		begin
			stat_image = 16'h0000;
			stat_image[`BIT_POR_EVT] = por_st;
			stat_image[`BIT_NOFRAME_EVT] = nof_st;
			stat_image[`BIT_LINK_EVT] = lpe_st;
			stat_image[`BIT_POR_EN] = por_en;
			stat_image[`BIT_NOFRAME_EN] = nof_en;
			stat_image[`BIT_LINK_EN] = lpe_en;
		end
	endfunction

	// Self-test register image: held count above, gap below
	function [15:0] selftest_image;
		input [7:0] held;
		input [7:0] gap;
		begin
			selftest_image = {held, gap};
		end
	endfunction

	// Packet length image; upper five bits read zero
	function [15:0] len_image;
		input [10:0] len;
		begin
			len_image = {5'h00, len};
		end
	endfunction

	// Decoded strobes; other offsets fall through untouched
	assign sel_stat = addr_is(addr, `OFS_IRQ_STATUS);
	assign sel_selftest = addr_is(addr, `OFS_ERRCOUNT_GAP);
	assign sel_len = addr_is(addr, `OFS_PKT_LEN);
	assign wr_stat = wr && sel_stat;
	assign wr_selftest = wr && sel_selftest;
	assign wr_len = wr && sel_len;
	assign rd_stat = rd && sel_stat;
	// Lock pulse only on a write with the lock bit set
	assign err_lock = wr_selftest && wdata[`BIT_ERR_LOCK]; // [RQ8]

	// Next state of the latched flags; any read of the status register clears
	always @*
	begin
		por_st_d = sticky_next(por_st_q, por_done_evt, rd_stat); // [RQ1] [RQ12]
		nof_st_d = sticky_next(nof_st_q, no_frame_evt, rd_stat); // [RQ2] [RQ12]
		lpe_st_d = sticky_next(lpe_st_q, link_partner_state_event, rd_stat); // [RQ3] [RQ12]
	end

	// Power-on-reset done flag
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_st_q <= 1'b0;
		end
		else
		begin
			por_st_q <= por_st_d; // [RQ1]
		end
	end

	// No-frame-detected flag
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nof_st_q <= 1'b0;
		end
		else
		begin
			nof_st_q <= nof_st_d; // [RQ2]
		end
	end

	// Link-partner-state flag
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lpe_st_q <= 1'b0;
		end
		else
		begin
			lpe_st_q <= lpe_st_d; // [RQ3]
		end
	end

	// Enable next values; flag bits of the same register are not writable
	always @*
	begin
		por_en_d = field_bit_next(por_en_q, wr_stat, wdata[`BIT_POR_EN]); // [RQ4]
		nof_en_d = field_bit_next(nof_en_q, wr_stat, wdata[`BIT_NOFRAME_EN]); // [RQ5]
		lpe_en_d = field_bit_next(lpe_en_q, wr_stat, wdata[`BIT_LINK_EN]); // [RQ6]
	end

	// Power-on-reset done enable, on by default
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_en_q <= `RST_POR_EN; // [RQ4]
		end
		else
		begin
			por_en_q <= por_en_d; // [RQ4]
		end
	end

	// No-frame-detected enable
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nof_en_q <= `RST_NOFRAME_EN; // [RQ5]
		end
		else
		begin
			nof_en_q <= nof_en_d; // [RQ5]
		end
	end

	// Link-partner-state enable
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lpe_en_q <= `RST_LINK_EN; // [RQ6]
		end
		else
		begin
			lpe_en_q <= lpe_en_d; // [RQ6]
		end
	end

	// Gap next value; a lock write also rewrites the gap field
	always @*
	begin
		if (wr_selftest)
			gap_words_d = wdata[7:0]; // [RQ10]
		else
			gap_words_d = gap_words_q;
	end

	// Inter-packet gap in four-byte units
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_words_q <= `RST_GAP; // [RQ10]
		end
		else
		begin
			gap_words_q <= gap_words_d; // [RQ10]
		end
	end

	// Packet length next value
	always @*
	begin
		if (wr_len)
			pkt_len_d = wdata[10:0]; // [RQ11]
		else
			pkt_len_d = pkt_len_q;
	end

	// Packet length in bytes
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pkt_len_q <= `RST_PKT_LEN; // [RQ11]
		end
		else
		begin
			pkt_len_q <= pkt_len_d; // [RQ11]
		end
	end

	// Counter kept in its own module; running count stays internal
	err_counter #(
		.W(8)
	) u_err (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.err_byte(err_byte),
		.wrap_mode(err_wrap_mode),
		.lock(err_lock),
		.count_q(),
		.held_q(err_held)
	);

	// Read mux; unmapped addresses read zero
	always @*
	begin
		rdata_d = 16'h0000;
		case (addr)
			`OFS_IRQ_STATUS:
			begin
				rdata_d = stat_image(por_st_q, nof_st_q, lpe_st_q, por_en_q, nof_en_q, lpe_en_q); // [RQ1] [RQ2] [RQ3]
			end
			`OFS_ERRCOUNT_GAP:
			begin
				rdata_d = selftest_image(err_held, gap_words_q); // [RQ7] [RQ8]
			end
			`OFS_PKT_LEN:
			begin
				rdata_d = len_image(pkt_len_q); // [RQ11]
			end
			default: rdata_d = 16'h0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= 16'h0000;
		end
		else if (rd)
		begin
			rdata_q <= rdata_d;
		end
		else
		begin
			rdata_q <= 16'h0000;
		end
	end

	// Per-source pending terms; combinational so the line follows the flags at once
	assign pend_por = por_st_q & por_en_q; // [RQ12]
	assign pend_nof = nof_st_q & nof_en_q; // [RQ12]
	assign pend_lpe = lpe_st_q & lpe_en_q; // [RQ12]

	// Level interrupt, high while any enabled flag is pending
	assign irq = pend_por | pend_nof | pend_lpe; // [RQ12]
endmodule

// ### design/phy_selftest_defs.vh
// Register offsets, field positions and reset values of the interrupt and self-test registers
`ifndef PHY_SELFTEST_DEFS_VH
`define PHY_SELFTEST_DEFS_VH
`define ADDR_W 9
`define OFS_IRQ_STATUS 9'h018
`define OFS_ERRCOUNT_GAP 9'h01b
`define OFS_PKT_LEN 9'h01c
`define BIT_POR_EVT 12
`define BIT_NOFRAME_EVT 11
`define BIT_LINK_EVT 8
`define BIT_POR_EN 4
`define BIT_NOFRAME_EN 3
`define BIT_LINK_EN 0
`define BIT_ERR_LOCK 15
`define RST_POR_EN 1'b1
`define RST_NOFRAME_EN 1'b0
`define RST_LINK_EN 1'b0
`define RST_GAP 8'h7d
`define RST_PKT_LEN 11'h5ee
`define ERR_MAX 8'hff
`endif

// ### tb/regs_chk_assertions.sv
// Assertion checker for the interrupt and self-test registers
`timescale 1ns/10ps
module regs_chk (
	input wire ref_clk,
	input wire rst_n,
	input wire rd,
	input wire irq,
	input wire [8:0] addr,
	input wire [15:0] rdata_q,
	input wire por_done_evt,
	input wire no_frame_evt,
	input wire link_partner_state_event,
	input wire [7:0] gap_words_q,
	input wire [10:0] pkt_len_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Status read and the enabled pending events it shows
	wire rs = rd && addr == 9'h018;
	wire [4:0] hit = rdata_q[12:8] & {rdata_q[4:3], 2'h0, rdata_q[0]};
	AST_POR: assert property ($past(por_done_evt) && rs |=> rdata_q[12]) else $error("por");
	AST_NOF: assert property ($past(no_frame_evt) && rs |=> rdata_q[11]) else $error("nof");
	AST_LINK_EVT: assert property ($past(link_partner_state_event) && rs |=> rdata_q[8]) else $error("link event");
	AST_RSV: assert property (rs |=> rdata_q[15:13] == 3'h0) else $error("rsv");
	AST_RSV2: assert property (rs |=> rdata_q[10:9] == 2'h0) else $error("rsv2");
	AST_IRQ: assert property (rs |=> $past(irq) == |hit) else $error("irq");
	AST_GAP: assert property (rd && addr == 9'h01b |=> rdata_q[7:0] == gap_words_q) else $error("gap");
	AST_LEN: assert property (rd && addr == 9'h01c |=> rdata_q == {5'h0, pkt_len_q}) else $error("len");
endmodule
bind phy_irq3_and_prbs_selftest_regs regs_chk chk (.*);

// ### tb/test_phy_irq3_and_prbs_selftest_regs.sv
// Self-checking bench for the interrupt and self-test registers
`timescale 1ns/10ps
module test_phy_irq3_and_prbs_selftest_regs;
	reg ref_clk = 0, rst_n = 0, wr = 0, rd = 0, err_byte = 0, err_wrap_mode = 0;
	reg [8:0] addr = 0;
	reg [15:0] wdata = 0, d;
	reg [2:0] ev = 0;
	reg [7:0] n;
	integer seed = 32'hc5ed, fail_count = 0, n_tests = 0, i;
	wire [15:0] rdata_q;
	wire [7:0] gap_words_q;
	wire [10:0] pkt_len_q;
	wire irq, por_done_evt = ev[2], no_frame_evt = ev[1], link_partner_state_event = ev[0];
	phy_irq3_and_prbs_selftest_regs DUT (.*);
	always #12.5 ref_clk = ~ref_clk;
	task chk(input [15:0] got, exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: %h %h", $time, got, exp);
		end
	end
	endtask
	// One-cycle strobe; read data checked in the following cycle
	task acc(input w, input [8:0] a, input [15:0] v);
	begin
		@(posedge ref_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		wr <= 0;
		rd <= 0;
		#1 if (!w) chk(rdata_q, v);
	end
	endtask
	// Event pulse or a burst of k errored bytes
	task drive(input [2:0] m, input integer k);
	begin
		@(posedge ref_clk);
		ev <= m;
		err_byte <= k > 0;
		repeat (k > 0 ? k : 1) @(posedge ref_clk);
		ev <= 0;
		err_byte <= 0;
	end
	endtask
	task tally_and_finish;
	begin
		$display("mismatches %0d of %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// Main sequence
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1;
		acc(0, 9'h018, 16'h0010);
		acc(0, 9'h01b, 16'h007d);
		acc(0, 9'h01c, 16'h05ee);
		chk({8'h0, gap_words_q}, 16'h007d);
		chk({5'h0, pkt_len_q}, 16'h05ee);
		for (i = 0; i < 4; i = i + 1)
		begin
			d = $random(seed);
			acc(1, 9'h01c, d);
			acc(1, 9'h01b, d & 16'h7fff);
			acc(0, 9'h01c, {5'h0, d[10:0]});
			acc(0, 9'h01b, {8'h00, d[7:0]});
			chk({5'h0, pkt_len_q}, {5'h0, d[10:0]});
			chk({8'h0, gap_words_q}, {8'h0, d[7:0]});
		end
		acc(1, 9'h100, 16'hffff);
		acc(0, 9'h100, 16'h0000);
		acc(1, 9'h018, 16'h0009);
		for (i = 0; i < 3; i = i + 1)
		begin
			drive(3'h4 >> i, 0);
			#1 chk({15'h0, irq}, {15'h0, i != 0});
			acc(0, 9'h018, 16'h0009 | (i == 0 ? 16'h1000 : 16'h0800 >> (3 * i - 3)));
			acc(0, 9'h018, 16'h0009);
			chk({15'h0, irq}, 16'h0);
		end
		// Event in the read-clear cycle must survive the clear
		ev <= 3'h2;
		acc(0, 9'h018, 16'h0809);
		ev <= 0;
		acc(0, 9'h018, 16'h0809);
		acc(0, 9'h018, 16'h0009);
		drive(0, 300);
		acc(1, 9'h01b, 16'h8000 | d[7:0]);
		acc(0, 9'h01b, {8'hff, d[7:0]});
		n = {1'b0, d[14:8]} + 8'h01;
		drive(0, n);
		acc(1, 9'h01b, 16'h8000 | d[7:0]);
		acc(0, 9'h01b, {n, d[7:0]});
		err_wrap_mode <= 1;
		drive(0, 260);
		acc(1, 9'h01b, 16'h8000 | d[7:0]);
		acc(0, 9'h01b, {8'h04, d[7:0]});
		tally_and_finish;
	end
	// Hang guard far beyond the expected run
	initial
	begin
		#200000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
endmodule
